// ---- rtl/tmtc_pkg.sv ----
// Package: register map, bit positions and constants of the timer block
`default_nettype none
package tmtc_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_TIMER_CONTROL_REG = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_REG    = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW_BYTE       = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW_BYTE       = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH_BYTE      = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH_BYTE      = 8'h8d;
  localparam logic [7:0] ADDR_TIMER2_CONTROL    = 8'hc8;
  localparam logic [7:0] ADDR_TIMER2_MODE       = 8'hc9;
  localparam logic [7:0] ADDR_T2_CAPTURE_LOW    = 8'hca;
  localparam logic [7:0] ADDR_T2_CAPTURE_HIGH   = 8'hcb;
  localparam logic [7:0] ADDR_T2_COUNT_LOW      = 8'hcc;
  localparam logic [7:0] ADDR_T2_COUNT_HIGH     = 8'hcd;
  // Timer control register bits
  localparam int BIT_T1_OVF = 7;
  localparam int BIT_T1_RUN = 6;
  localparam int BIT_T0_OVF = 5;
  localparam int BIT_T0_RUN = 4;
  // Timer mode register bits
  localparam int BIT_T1_GATE     = 7;
  localparam int BIT_T1_COUNTER  = 6;
  localparam int BIT_T1_MODE_LSB = 4;
  localparam int BIT_T0_GATE     = 3;
  localparam int BIT_T0_COUNTER  = 2;
  localparam int BIT_T0_MODE_LSB = 0;
  // Timer 2 control register bits
  localparam int BIT_T2_OVF      = 7;
  localparam int BIT_T2_EXT_FLAG = 6;
  localparam int BIT_RX_CLK_SEL  = 5;
  localparam int BIT_TX_CLK_SEL  = 4;
  localparam int BIT_T2_EXT_EN   = 3;
  localparam int BIT_T2_RUN      = 2;
  localparam int BIT_T2_COUNTER  = 1;
  localparam int BIT_CAP_RELOAD  = 0;
  // Timer 2 mode register bits
  localparam int BIT_T2_OUT_EN   = 1;
  localparam int BIT_DOWN_EN     = 0;
  // Reset values and the all-ones count
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [1:0]  RST_T2_MODE   = 2'h0;
  localparam logic        RST_PORT_BIT  = 1'b1;
  localparam logic [15:0] COUNT_ALL_ONE = 16'hffff;
  // Clocks per machine cycle
  localparam int MCYCLE_CLKS = 12;
  // Timer 0/1 operating modes, encoded 00..11 in declaration order
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_8BIT_RELOAD,
    MODE_SPLIT
  } tmtc_mode_t;
endpackage : tmtc_pkg
`default_nettype wire

// ---- rtl/tmtc_sync.sv ----
// Two-stage synchroniser for one pin, with a falling edge pulse
`default_nettype none
module tmtc_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      fall_out
);
  logic meta_ff;   // First stage, read only by the second
  logic sync_ff;   // Second stage, safe to use
  logic prev_ff;   // Delayed copy for edge detection

  // Pins idle high, so reset to one to avoid a false edge
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign fall_out  = prev_ff & ~sync_ff;
endmodule : tmtc_sync
`default_nettype wire

// ---- rtl/tmtc_top.sv ----
// Timer 0/1 modes and timer 2 control logic behind the SFR port
`default_nettype none
module tmtc_top
  import tmtc_pkg::*;
#(
  parameter int MCYCLE_CLKS_P = tmtc_pkg::MCYCLE_CLKS
) (
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       T0_INT_ACK,
  input  wire logic       T1_INT_ACK,
  input  wire logic       T2_INT_ENABLE,
  input  wire logic [1:0] SERIAL_MODE,
  input  wire logic       EXT_INTERRUPT_ZERO_INPUT,
  input  wire logic       EXT_INTERRUPT_ONE_INPUT,
  input  wire logic       T0_COUNT_PIN,
  input  wire logic       T1_COUNT_PIN,
  input  wire logic       T2_COUNT_PIN,
  input  wire logic       T2_TRIGGER_PIN,
  output logic            T0_OVERFLOW_FLAG,
  output logic            T1_OVERFLOW_FLAG,
  output logic            T2_IRQ,
  output logic            RX_BAUD_TICK,
  output logic            TX_BAUD_TICK,
  output logic            PORT1_BIT0
);
  import tmtc_pkg::*;

  // Refuse a prescaler that cannot divide
  if (MCYCLE_CLKS_P < 1 || MCYCLE_CLKS_P > 255)
  begin : g_bad_param
    $error("MCYCLE_CLKS_P must be 1 to 255");
  end

  localparam int NPIN = 6;
  localparam logic [7:0] PRESC_LAST = 8'(MCYCLE_CLKS_P - 1);

  logic [NPIN-1:0] pin_raw;    // Pins in fixed order
  logic [NPIN-1:0] pin_lvl;    // Synchronised levels
  logic [NPIN-1:0] pin_fall;   // One-cycle falling edge pulses

  logic [7:0]  timer_control_reg_ff;        // Timer control register
  logic [7:0]  timer_mode_reg_ff;        // Timer mode register
  logic [7:0]  tl0_ff;         // Timer 0 low byte
  logic [7:0]  th0_ff;         // Timer 0 high byte
  logic [7:0]  tl1_ff;         // Timer 1 low byte
  logic [7:0]  th1_ff;         // Timer 1 high byte
  logic [7:0]  timer2_control_ff;       // Timer 2 control register
  logic [1:0]  timer2_mode_ff;       // Timer 2 mode register, two live bits
  logic [15:0] rcap_ff;        // Timer 2 capture / reload value
  logic [15:0] cnt2_ff;        // Timer 2 count
  logic [15:0] nxt_cnt2;       // Next timer 2 count
  logic [7:0]  rdata_ff;       // Read data holding register
  logic [7:0]  nxt_rdata;      // Read mux output
  logic [7:0]  presc_ff;       // Machine cycle prescaler
  logic        irq2_ff;        // Registered timer 2 request
  logic        rx_tick_ff;     // Registered receive baud tick
  logic        tx_tick_ff;     // Registered transmit baud tick
  logic        port_bit_ff;    // Port 1 bit 0 output latch

  // Pin order: ext_interrupt_zero_input, int1, t0, t1, t2 count, t2 trigger
  assign pin_raw = {T2_TRIGGER_PIN, T2_COUNT_PIN, T1_COUNT_PIN,
                    T0_COUNT_PIN, EXT_INTERRUPT_ONE_INPUT,
                    EXT_INTERRUPT_ZERO_INPUT};

  // One synchroniser per pin; pins come from outside this clock
  for (genvar i = 0; i < NPIN; i++)
  begin : g_sync
    tmtc_sync u_sync (
      .ref_clk   (REF_CLK),
      .sys_rst   (SYS_RST),
      .pin_in    (pin_raw[i]),
      .level_out (pin_lvl[i]),
      .fall_out  (pin_fall[i])
    );
  end

  // Write strobes, one per register
  logic wr_timer_control_reg, wr_timer_mode_reg, wr_tl0, wr_th0, wr_tl1, wr_th1;
  logic wr_timer2_control, wr_timer2_mode, wr_rcl, wr_rch, wr_tl2, wr_th2;
  assign wr_timer_control_reg  = SFR_WR && SFR_ADDR == ADDR_TIMER_CONTROL_REG;
  assign wr_timer_mode_reg  = SFR_WR && SFR_ADDR == ADDR_TIMER_MODE_REG;
  assign wr_tl0   = SFR_WR && SFR_ADDR == ADDR_T0_LOW_BYTE;
  assign wr_th0   = SFR_WR && SFR_ADDR == ADDR_T0_HIGH_BYTE;
  assign wr_tl1   = SFR_WR && SFR_ADDR == ADDR_T1_LOW_BYTE;
  assign wr_th1   = SFR_WR && SFR_ADDR == ADDR_T1_HIGH_BYTE;
  assign wr_timer2_control = SFR_WR && SFR_ADDR == ADDR_TIMER2_CONTROL;
  assign wr_timer2_mode = SFR_WR && SFR_ADDR == ADDR_TIMER2_MODE;
  assign wr_rcl   = SFR_WR && SFR_ADDR == ADDR_T2_CAPTURE_LOW;
  assign wr_rch   = SFR_WR && SFR_ADDR == ADDR_T2_CAPTURE_HIGH;
  assign wr_tl2   = SFR_WR && SFR_ADDR == ADDR_T2_COUNT_LOW;
  assign wr_th2   = SFR_WR && SFR_ADDR == ADDR_T2_COUNT_HIGH;

  // Machine cycle tick from the prescaler
  logic mtick;
  assign mtick = presc_ff == PRESC_LAST;

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      presc_ff <= RST_BYTE;
    else if (mtick)
      presc_ff <= RST_BYTE;
    else
      presc_ff <= presc_ff + 8'h01;
  end

  // One count step for timer 0 or 1; returns {overflow, high, low}
  function automatic logic [16:0] step(input tmtc_mode_t md,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [5:0]  lo5;
    logic [16:0] full;
    lo5  = {1'b0, lo[4:0]} + 6'h01;
    full = {1'b0, hi, lo} + 17'h0_0001;
    step = {1'b0, hi, lo};
    unique case (md)
      MODE_13BIT:        // Top three low bits left as they are
        step = {lo5[5] && hi == 8'hff, hi + {7'h00, lo5[5]},
                lo[7:5], lo5[4:0]};
      MODE_16BIT:        // Plain sixteen bit wrap
        step = full;
      MODE_8BIT_RELOAD:  // Low byte reloads from the high byte
        step = {lo == 8'hff, hi, (lo == 8'hff) ? hi : lo + 8'h01};
      MODE_SPLIT:        // Low byte alone; high handled apart
        step = {lo == 8'hff, hi, lo + 8'h01};
    endcase
  endfunction : step

  // Mode fields, two bits each, encoded 00 to 11
  tmtc_mode_t t0_mode, t1_mode;
  assign t0_mode = tmtc_mode_t'(timer_mode_reg_ff[BIT_T0_MODE_LSB +: 2]);
  assign t1_mode = tmtc_mode_t'(timer_mode_reg_ff[BIT_T1_MODE_LSB +: 2]);

  // Timer 0 low part enable: run and (no gate or ext_interrupt_zero_input high)
  logic t0_tick, th0_tick, t1_run, t1_tick, t0_split;
  logic [16:0] t0_step, t1_step;
  logic t0_ovf, th0_ovf, t1_ovf;
  assign t0_split = t0_mode == MODE_SPLIT;
  assign t0_tick  = timer_control_reg_ff[BIT_T0_RUN]
                    && (!timer_mode_reg_ff[BIT_T0_GATE] || pin_lvl[0])
                    && (timer_mode_reg_ff[BIT_T0_COUNTER] ? pin_fall[2] : mtick);
  // High byte in split mode: machine cycles under timer 1 run bit
  assign th0_tick = t0_split && timer_control_reg_ff[BIT_T1_RUN] && mtick;
  // Timer 1 loses its run bit to timer 0 in split mode, and then
  // runs whenever it is out of its own mode 3
  assign t1_run   = t0_split ? 1'b1
                    : timer_control_reg_ff[BIT_T1_RUN]
                      && (!timer_mode_reg_ff[BIT_T1_GATE] || pin_lvl[1]);
  assign t1_tick  = t1_run && t1_mode != MODE_SPLIT
                    && (timer_mode_reg_ff[BIT_T1_COUNTER] ? pin_fall[3] : mtick);
  assign t0_step  = step(t0_mode, tl0_ff, th0_ff);
  assign t1_step  = step(t1_mode, tl1_ff, th1_ff);
  assign t0_ovf   = t0_tick && t0_step[16];
  assign th0_ovf  = th0_tick && th0_ff == 8'hff;
  assign t1_ovf   = t1_tick && t1_step[16];

  // Timer 0 count bytes; a write wins over a count step, and the
  // run bit itself never touches the count
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tl0_ff <= RST_BYTE;
      th0_ff <= RST_BYTE;
    end
    else
    begin
      if (wr_tl0)
        tl0_ff <= SFR_WDATA;
      else if (t0_tick)
        tl0_ff <= t0_step[7:0];
      if (wr_th0)
        th0_ff <= SFR_WDATA;
      else if (th0_tick)
        th0_ff <= th0_ff + 8'h01;
      else if (t0_tick && !t0_split)
        th0_ff <= t0_step[15:8];
    end
  end

  // Timer 1 count bytes, held while its mode is 3
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tl1_ff <= RST_BYTE;
      th1_ff <= RST_BYTE;
    end
    else
    begin
      if (wr_tl1)
        tl1_ff <= SFR_WDATA;
      else if (t1_tick)
        tl1_ff <= t1_step[7:0];
      if (wr_th1)
        th1_ff <= SFR_WDATA;
      else if (t1_tick)
        th1_ff <= t1_step[15:8];
    end
  end

  // Timer mode register, plain storage
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      timer_mode_reg_ff <= RST_BYTE;
    else if (wr_timer_mode_reg)
      timer_mode_reg_ff <= SFR_WDATA;
  end

  // Timer control: later assignments win, so a set beats both the
  // vectoring clear and a software write in the same cycle
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      timer_control_reg_ff <= RST_BYTE;
    else
    begin
      if (wr_timer_control_reg)
        timer_control_reg_ff <= SFR_WDATA;
      if (T0_INT_ACK)
        timer_control_reg_ff[BIT_T0_OVF] <= 1'b0;
      if (T1_INT_ACK)
        timer_control_reg_ff[BIT_T1_OVF] <= 1'b0;
      if (t0_ovf)
        timer_control_reg_ff[BIT_T0_OVF] <= 1'b1;
      // Split mode hands the timer 1 flag to timer 0 high byte
      if (t0_split ? th0_ovf : t1_ovf)
        timer_control_reg_ff[BIT_T1_OVF] <= 1'b1;
    end
  end

  // Timer 2 control decode
  logic baud, t2_down, t2_tick, t2_wrap, ext_evt, ext_act, cap_mode;
  assign baud     = timer2_control_ff[BIT_RX_CLK_SEL] || timer2_control_ff[BIT_TX_CLK_SEL];
  assign cap_mode = timer2_control_ff[BIT_CAP_RELOAD] && !baud;
  // Direction follows the trigger pin only in reload mode
  assign t2_down  = timer2_mode_ff[BIT_DOWN_EN] && !cap_mode && !baud
                    && !pin_lvl[5];
  assign t2_tick  = timer2_control_ff[BIT_T2_RUN]
                    && (timer2_control_ff[BIT_T2_COUNTER] ? pin_fall[4] : mtick);
  assign t2_wrap  = t2_tick
                    && cnt2_ff == (t2_down ? rcap_ff : COUNT_ALL_ONE);
  // Trigger edges are dropped while timer 2 clocks the serial port
  assign ext_evt  = pin_fall[5] && timer2_control_ff[BIT_T2_EXT_EN] && !baud;
  // In up/down mode edges steer direction instead of reloading
  assign ext_act  = ext_evt && (cap_mode || !timer2_mode_ff[BIT_DOWN_EN]);

  // Next timer 2 count
  always_comb
  begin
    nxt_cnt2 = cnt2_ff;
    if (t2_tick)
    begin
      if (t2_wrap)
        nxt_cnt2 = cap_mode ? 16'h0000
                 : (t2_down ? COUNT_ALL_ONE : rcap_ff);
      else if (t2_down)
        nxt_cnt2 = cnt2_ff - 16'h0001;
      else
        nxt_cnt2 = cnt2_ff + 16'h0001;
    end
    if (ext_act && !cap_mode)
      nxt_cnt2 = rcap_ff;
    if (wr_tl2)
      nxt_cnt2[7:0] = SFR_WDATA;
    if (wr_th2)
      nxt_cnt2[15:8] = SFR_WDATA;
  end

  // Timer 2 count and capture registers
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cnt2_ff <= {RST_BYTE, RST_BYTE};
      rcap_ff <= {RST_BYTE, RST_BYTE};
    end
    else
    begin
      cnt2_ff <= nxt_cnt2;
      if (ext_act && cap_mode)
        rcap_ff <= cnt2_ff;
      if (wr_rcl)
        rcap_ff[7:0] <= SFR_WDATA;
      if (wr_rch)
        rcap_ff[15:8] <= SFR_WDATA;
    end
  end

  // Timer 2 control and mode registers; flags set over writes
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      timer2_control_ff <= RST_BYTE;
      timer2_mode_ff <= RST_T2_MODE;
    end
    else
    begin
      if (wr_timer2_control)
        timer2_control_ff <= SFR_WDATA;
      if (wr_timer2_mode)
        timer2_mode_ff <= SFR_WDATA[1:0];
      if (t2_wrap && !baud)
        timer2_control_ff[BIT_T2_OVF] <= 1'b1;
      if (ext_act)
        timer2_control_ff[BIT_T2_EXT_FLAG] <= 1'b1;
    end
  end

  // Timer 2 request, baud ticks and port toggle
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      irq2_ff     <= 1'b0;
      rx_tick_ff  <= 1'b0;
      tx_tick_ff  <= 1'b0;
      port_bit_ff <= RST_PORT_BIT;
    end
    else
    begin
      irq2_ff <= T2_INT_ENABLE && (timer2_control_ff[BIT_T2_OVF]
                 || (timer2_control_ff[BIT_T2_EXT_FLAG]
                     && !timer2_mode_ff[BIT_DOWN_EN]));
      // Only serial modes 1 and 3 take a timer baud clock
      rx_tick_ff <= SERIAL_MODE[0] && (timer2_control_ff[BIT_RX_CLK_SEL]
                    ? t2_wrap : t1_ovf);
      tx_tick_ff <= SERIAL_MODE[0] && (timer2_control_ff[BIT_TX_CLK_SEL]
                    ? t2_wrap : t1_ovf);
      if (timer2_mode_ff[BIT_T2_OUT_EN] && t2_wrap)
        port_bit_ff <= ~port_bit_ff;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    unique case (SFR_ADDR)
      ADDR_TIMER_CONTROL_REG: nxt_rdata = timer_control_reg_ff;
      ADDR_TIMER_MODE_REG:    nxt_rdata = timer_mode_reg_ff;
      ADDR_T0_LOW_BYTE:       nxt_rdata = tl0_ff;
      ADDR_T1_LOW_BYTE:       nxt_rdata = tl1_ff;
      ADDR_T0_HIGH_BYTE:      nxt_rdata = th0_ff;
      ADDR_T1_HIGH_BYTE:      nxt_rdata = th1_ff;
      ADDR_TIMER2_CONTROL:    nxt_rdata = timer2_control_ff;
      ADDR_TIMER2_MODE:       nxt_rdata = {6'h00, timer2_mode_ff};
      ADDR_T2_CAPTURE_LOW:    nxt_rdata = rcap_ff[7:0];
      ADDR_T2_CAPTURE_HIGH:   nxt_rdata = rcap_ff[15:8];
      ADDR_T2_COUNT_LOW:      nxt_rdata = cnt2_ff[7:0];
      ADDR_T2_COUNT_HIGH:     nxt_rdata = cnt2_ff[15:8];
      default:                nxt_rdata = RST_BYTE;
    endcase
  end

  // Read data register; holds until the next read
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rdata_ff <= RST_BYTE;
    else if (SFR_RD)
      rdata_ff <= nxt_rdata;
  end

  assign SFR_RDATA        = rdata_ff;
  assign T0_OVERFLOW_FLAG = timer_control_reg_ff[BIT_T0_OVF];
  assign T1_OVERFLOW_FLAG = timer_control_reg_ff[BIT_T1_OVF];
  assign T2_IRQ           = irq2_ff;
  assign RX_BAUD_TICK     = rx_tick_ff;
  assign TX_BAUD_TICK     = tx_tick_ff;
  assign PORT1_BIT0       = port_bit_ff;

  // Checks on the timing of flags and counts
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  property p_ext_flag;
    ext_act |=> timer2_control_ff[BIT_T2_EXT_FLAG];
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("external flag not set on trigger");

  property p_irq_down;
    timer2_mode_ff[BIT_DOWN_EN] && !timer2_control_ff[BIT_T2_OVF] && !SFR_WR |=> !T2_IRQ;
  endproperty
  a_irq_down: assert property (p_irq_down)
    else $error("request raised in up/down mode");

  property p_rx_sel;
    SERIAL_MODE[0] && timer2_control_ff[BIT_RX_CLK_SEL] && t2_wrap
      |=> RX_BAUD_TICK;
  endproperty
  a_rx_sel: assert property (p_rx_sel)
    else $error("receive tick missing");

  property p_tx_t1;
    SERIAL_MODE[0] && !timer2_control_ff[BIT_TX_CLK_SEL] && !t1_ovf
      |=> !TX_BAUD_TICK;
  endproperty
  a_tx_t1: assert property (p_tx_t1)
    else $error("transmit tick without timer 1 overflow");

  property p_edge_ignored;
    pin_fall[5] && baud && !SFR_WR |=> $stable(rcap_ff);
  endproperty
  a_edge_ignored: assert property (p_edge_ignored)
    else $error("trigger edge acted in baud mode");

  property p_t2_stop;
    !timer2_control_ff[BIT_T2_RUN] && !ext_act && !SFR_WR |=> $stable(cnt2_ff);
  endproperty
  a_t2_stop: assert property (p_t2_stop)
    else $error("timer 2 moved while stopped");

  property p_t0_flag;
    t0_ovf && (t0_mode == MODE_13BIT || t0_mode == MODE_16BIT)
      |=> T0_OVERFLOW_FLAG && tl0_ff[4:0] == 5'h00;
  endproperty
  a_t0_flag: assert property (p_t0_flag)
    else $error("timer 0 wrap did not flag");

  property p_gate_hold;
    timer_mode_reg_ff[BIT_T0_GATE] && !pin_lvl[0] && !SFR_WR |=> $stable(tl0_ff);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("timer 0 counted while gated off");

  property p_reload;
    t0_mode == MODE_8BIT_RELOAD && t0_tick && tl0_ff == 8'hff && !SFR_WR
      |=> tl0_ff == $past(th0_ff) && $stable(th0_ff);
  endproperty
  a_reload: assert property (p_reload)
    else $error("mode 2 reload wrong");

  property p_t1_hold;
    t1_mode == MODE_SPLIT && !SFR_WR |=> $stable({th1_ff, tl1_ff});
  endproperty
  a_t1_hold: assert property (p_t1_hold)
    else $error("timer 1 moved in mode 3");

  property p_no_tf2;
    baud && !timer2_control_ff[BIT_T2_OVF] && !SFR_WR |=> !timer2_control_ff[BIT_T2_OVF];
  endproperty
  a_no_tf2: assert property (p_no_tf2)
    else $error("timer 2 flag set in baud mode");

  property p_toggle;
    timer2_mode_ff[BIT_T2_OUT_EN] && t2_wrap |=> PORT1_BIT0 != $past(PORT1_BIT0);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("port bit did not toggle");

  c_t0_wrap:  cover property (t0_ovf);
  c_split_hi: cover property (th0_ovf);
  c_capture:  cover property (ext_act && cap_mode);
  c_baud:     cover property (RX_BAUD_TICK && timer2_control_ff[BIT_RX_CLK_SEL]);
endmodule : tmtc_top
`default_nettype wire

// ---- testbench/tmtc_top_test.sv ----
// Self-checking testbench for the timer block
`default_nettype none
module tmtc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tmtc_pkg::*;
  // Design stimulus and observed outputs
  logic       ref_clk, sys_rst, sfr_wr, sfr_rd, t0_ack, t1_ack, t2_ien;
  logic       ext_interrupt_zero_input_in, int1_in, t0_pin, t1_pin, t2_pin, t2_trig;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic [1:0] ser_mode;
  logic       t0_flag, t1_flag, t2_irq, rx_tick, tx_tick, port_bit;
  int         failures, n_tests, i;
  // Register rows: address, written byte, byte read back
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} tmtc_row_t;
  tmtc_row_t rows [6] = '{'{8'h89, 8'ha5, 8'ha5}, '{8'h8c, 8'h5a, 8'h5a},
    '{8'h8a, 8'h3c, 8'h3c}, '{8'hc9, 8'hff, 8'h03}, '{8'h90, 8'hff, 8'h00},
    '{8'hca, 8'h77, 8'h77}};
  // Fast prescaler keeps overflow waits short
  tmtc_top #(.MCYCLE_CLKS_P(2)) u_tmtc_top (.REF_CLK(ref_clk),
    .SYS_RST(sys_rst), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata),
    .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata),
    .T0_INT_ACK(t0_ack), .T1_INT_ACK(t1_ack), .T2_INT_ENABLE(t2_ien),
    .SERIAL_MODE(ser_mode), .EXT_INTERRUPT_ZERO_INPUT(ext_interrupt_zero_input_in),
    .EXT_INTERRUPT_ONE_INPUT(int1_in), .T0_COUNT_PIN(t0_pin),
    .T1_COUNT_PIN(t1_pin), .T2_COUNT_PIN(t2_pin), .T2_TRIGGER_PIN(t2_trig),
    .T0_OVERFLOW_FLAG(t0_flag), .T1_OVERFLOW_FLAG(t1_flag), .T2_IRQ(t2_irq),
    .RX_BAUD_TICK(rx_tick), .TX_BAUD_TICK(tx_tick), .PORT1_BIT0(port_bit));
  // Clock at 40 ns
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Two-cycle write, strobe dropped one step after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    sfr_addr = a;
    sfr_wdata = w;
    sfr_wr = 1'b1;
    @(posedge ref_clk);
    #1 sfr_wr = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr
  // Read: data valid after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge ref_clk);
    #1 sfr_rd = 1'b0;
    r = sfr_rdata;
    @(posedge ref_clk);
    #1;
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    rd(a, r);
    chk(r, exp);
  endtask : rd_chk
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // Hang guard, far beyond the expected run length
  initial
  begin
    #(40 * 20000);
    failures++;
    finish_test;
  end
  // Main sequence
  initial
  begin
    {sys_rst, sfr_wr, sfr_rd, t0_ack, t1_ack} = 5'b1_0000;
    {ext_interrupt_zero_input_in, int1_in, t0_pin, t1_pin, t2_pin, t2_trig, t2_ien} = 7'h7f;
    {sfr_addr, sfr_wdata, ser_mode, failures, n_tests} = '0;
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    rd_chk(ADDR_TIMER_CONTROL_REG, 8'h00);
    rd_chk(ADDR_TIMER2_CONTROL, 8'h00);
    chk({7'h0, port_bit}, 8'h01);
    $display("reset test done");
    // Register rows: storage, unused mode bits, unmapped address
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].w);
      rd_chk(rows[k].a, rows[k].r);
    end
    $display("register test done");
    // Thirteen-bit wrap: the low five bits carry into the high byte
    wr(8'h89, 8'h00);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'hfe);
    wr(8'h88, 8'h10);
    for (i = 0; i < 50 && t0_flag !== 1'b1; i++) @(posedge ref_clk);
    #1 chk({7'h0, t0_flag}, 8'h01);
    wr(8'h88, 8'h00);
    rd_chk(8'h8c, 8'h00);
    $display("mode 0 test done");
    // Sixteen-bit wrap sets the flag; acknowledge clears it
    wr(8'h89, 8'h01);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'hfe);
    wr(8'h88, 8'h10);
    for (i = 0; i < 50 && t0_flag !== 1'b1; i++) @(posedge ref_clk);
    #1 chk({7'h0, t0_flag}, 8'h01);
    t0_ack = 1'b1;
    @(posedge ref_clk);
    #1 t0_ack = 1'b0;
    @(posedge ref_clk);
    #1 chk({7'h0, t0_flag}, 8'h00);
    $display("mode 1 test done");
    // Auto-reload keeps the high byte
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h02);
    wr(8'h8c, 8'h9c);
    wr(8'h8a, 8'hff);
    wr(8'h88, 8'h10);
    for (i = 0; i < 50 && t0_flag !== 1'b1; i++) @(posedge ref_clk);
    #1 wr(8'h88, 8'h00);
    rd_chk(8'h8c, 8'h9c);
    rd(8'h8a, d);
    chk({7'h0, d >= 8'h9c && d < 8'ha8}, 8'h01);
    $display("mode 2 test done");
    // Gate low holds the count, gate high lets it run; the pin goes
    // low one write ahead of the run bit so its synchroniser settles
    wr(8'h89, 8'h09);
    ext_interrupt_zero_input_in = 1'b0;
    wr(8'h8a, 8'h10);
    wr(8'h88, 8'h10);
    repeat (20) @(posedge ref_clk);
    #1 rd_chk(8'h8a, 8'h10);
    ext_interrupt_zero_input_in = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1 rd(8'h8a, d);
    chk({7'h0, d !== 8'h10}, 8'h01);
    wr(8'h88, 8'h00);
    $display("gate test done");
    // Split mode: high byte runs on the timer 1 run bit and flag
    wr(8'h89, 8'h03);
    wr(8'h8c, 8'hfe);
    wr(8'h88, 8'h40);
    for (i = 0; i < 50 && t1_flag !== 1'b1; i++) @(posedge ref_clk);
    #1 chk({6'h0, t1_flag, t0_flag}, 8'h02);
    wr(8'h88, 8'h00);
    $display("split test done");
    // Trigger edge with external enable sets the flag and asks service;
    // down count is off so the edge reloads rather than steers
    wr(8'hc9, 8'h00);
    wr(8'hc8, 8'h08);
    t2_trig = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 rd_chk(8'hc8, 8'h48);
    chk({7'h0, t2_irq}, 8'h01);
    // Same edge while timer 2 clocks the serial port is ignored
    t2_trig = 1'b1;
    wr(8'hc8, 8'h18);
    t2_trig = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 rd_chk(8'hc8, 8'h18);
    $display("trigger test done");
    // Baud source: ticks come, overflow flag stays clear; the count
    // starts near the top so the first wrap comes soon
    ser_mode = 2'b01;
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hf0);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h34);
    // Poll just after each edge: the ticks stand for one cycle only
    for (i = 0; i < 200 && rx_tick !== 1'b1; i++) #40;
    chk({6'h0, rx_tick, tx_tick}, 8'h03);
    rd_chk(8'hc8, 8'h34);
    wr(8'hc8, 8'h00);
    $display("baud test done");
    // Output enable toggles the port bit on overflow
    wr(8'hc9, 8'h02);
    wr(8'hc8, 8'h04);
    for (i = 0; i < 200 && port_bit !== 1'b0; i++) @(posedge ref_clk);
    #1 chk({7'h0, port_bit}, 8'h00);
    $display("output test done");
    // Capture mode copies the count on a trigger edge
    wr(8'hc8, 8'h09);
    wr(8'hcc, 8'h34);
    t2_trig = 1'b1;
    wr(8'hcd, 8'h12);
    t2_trig = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 rd_chk(8'hca, 8'h34);
    rd_chk(8'hcb, 8'h12);
    $display("capture test done");
    finish_test;
  end
endmodule : tmtc_top_test
`default_nettype wire
